// ==== include/sbp_pkg.sv ====
// constants, register map and types of the serial bus port slave
`default_nettype none
package sbp_pkg;
	// ------------------------------------------------------------------
	// register map (byte addresses)
	// ------------------------------------------------------------------
	localparam int          ADDR_W    = 8;
	localparam logic [7:0]  REG_CTRL  = 8'h00;
	localparam logic [7:0]  REG_CMD   = 8'h04;
	localparam logic [7:0]  REG_STAT  = 8'h08;
	localparam logic [7:0]  REG_DATA  = 8'h0C;

	// ------------------------------------------------------------------
	// field positions
	// ------------------------------------------------------------------
	localparam int          CTRL_EN_BIT   = 0;
	localparam int          CTRL_TOUT_BIT = 1;
	localparam int          CTRL_ADDR_LSB = 8;
	localparam int          SADDR_W       = 7;
	localparam int          CMD_LSB       = 0;
	localparam int          CMD_ACKN_BIT  = 2;
	localparam int          STAT_APF_BIT  = 0;
	localparam int          STAT_DF_BIT   = 1;
	localparam int          STAT_CLR_BIT  = 2;
	localparam int          DATA_W        = 8;

	// ------------------------------------------------------------------
	// encodings
	// ------------------------------------------------------------------
	localparam logic [1:0]  CMD_NONE = 2'h0;
	localparam logic [1:0]  CMD_DONE = 2'h2;
	localparam logic [1:0]  CMD_RESP = 2'h3;
	localparam logic [1:0]  BUS_IDLE = 2'h1;
	localparam logic [1:0]  BUS_BUSY = 2'h3;
	localparam logic [3:0]  BYTE_BITS = 4'h8;

	// ------------------------------------------------------------------
	// timing
	// ------------------------------------------------------------------
	localparam int          CLK_PERIOD_NS = 50;
	localparam int          TOUT_US       = 25;
	localparam int          TOUT_CYC      = TOUT_US * 1000 / CLK_PERIOD_NS;
	localparam int          TOUT_W        = 12;

	// ------------------------------------------------------------------
	// types
	// ------------------------------------------------------------------
	typedef struct packed {
		logic [SADDR_W-1:0] addr;
		logic               tout_en;
		logic               enable;
	} sbp_ctrl_t;

	typedef struct packed {
		logic       rx_nack;
		logic [1:0] bus_condition;
		logic       read_dir;
		logic       clock_stretch_state;
		logic       tx_clash;
		logic       data_flag;
		logic       address_stop_flag;
	} sbp_status_t;

	typedef enum logic [6:0] {
		ST_IDLE = 7'h01,
		ST_ADDR = 7'h02,
		ST_AACK = 7'h04,
		ST_RX   = 7'h08,
		ST_DACK = 7'h10,
		ST_TX   = 7'h20,
		ST_TACK = 7'h40
	} sbp_state_t;
endpackage : sbp_pkg
`default_nettype wire

// ==== rtl/sbp_slave.sv ====
// two-wire serial bus port slave with flag and clock-stretch handling
// Functional notes
// - a START clears the transmit clash flag; a repeated START leaves it.
// - flag clear colliding with address set: flag and SCL hold stay.
// - timeout in the same cycle as START drops the transaction.
// - response command 0b11 clears data flag one cycle later.
//
// Our own choices: the APB interface to the registers and the address map.
`timescale 1ns/100ps
`default_nettype none
module sbp_slave #(
	parameter int TOUT_CYC = sbp_pkg::TOUT_CYC
) (
	// clock and reset
	input  wire logic        I_CLK,
	input  wire logic        I_SRST,
	// apb slave
	input  wire logic        I_PSEL,
	input  wire logic        I_PENABLE,
	input  wire logic        I_PWRITE,
	input  wire logic [7:0]  I_PADDR,
	input  wire logic [31:0] I_PWDATA,
	output logic      [31:0] O_PRDATA,
	output logic             O_PREADY,
	output logic             O_PSLVERR,
	// two-wire bus pins
	input  wire logic        I_SCL,
	output logic             O_SCL_O,
	output logic             O_SCL_OE,
	input  wire logic        I_SDA,
	output logic             O_SDA_O,
	output logic             O_SDA_OE
);
	// ------------------------------------------------------------------
	// pin synchronisers
	// ------------------------------------------------------------------
	logic [2:0] scl_q, scl_d, sda_q, sda_d;
	always_comb begin
		scl_d = {scl_q[1:0], I_SCL};
		sda_d = {sda_q[1:0], I_SDA};
	end
	always_ff @(posedge I_CLK) begin
		if (I_SRST) begin
			scl_q <= 3'h7;
			sda_q <= 3'h7;
		end else begin
			scl_q <= scl_d;
			sda_q <= sda_d;
		end
	end
	logic scl_s, sda_s, scl_rise, scl_fall, start_ev, stop_ev;
	assign scl_s    = scl_q[1];
	assign sda_s    = sda_q[1];
	assign scl_rise = scl_q[1] & ~scl_q[2];
	assign scl_fall = ~scl_q[1] & scl_q[2];
	assign start_ev = scl_s & ~sda_q[1] & sda_q[2];
	assign stop_ev  = scl_s & sda_q[1] & ~sda_q[2];

	// ------------------------------------------------------------------
	// apb decode
	// ------------------------------------------------------------------
	function automatic logic hit(input logic [7:0] a, input logic [7:0] r);
		hit = (a == r);
	endfunction : hit

	logic acc, wr, rd_ok, cmd_wr, st_wr;
	logic [1:0] cmd;
	assign acc    = I_PSEL & I_PENABLE;
	assign wr     = acc & I_PWRITE;
	assign rd_ok  = hit(I_PADDR, sbp_pkg::REG_CTRL) |
			hit(I_PADDR, sbp_pkg::REG_CMD) |
			hit(I_PADDR, sbp_pkg::REG_STAT) |
			hit(I_PADDR, sbp_pkg::REG_DATA);
	assign cmd_wr = wr & hit(I_PADDR, sbp_pkg::REG_CMD);
	assign st_wr  = wr & hit(I_PADDR, sbp_pkg::REG_STAT);
	assign cmd    = cmd_wr ? I_PWDATA[sbp_pkg::CMD_LSB +: 2]
			: sbp_pkg::CMD_NONE;
	assign O_PREADY  = 1'b1;
	assign O_PSLVERR = I_PSEL & ~rd_ok;

	// ------------------------------------------------------------------
	// engine state
	// ------------------------------------------------------------------
	sbp_pkg::sbp_ctrl_t   ctrl_q, ctrl_d;
	sbp_pkg::sbp_state_t  st_q, st_d;
	sbp_pkg::sbp_status_t stat;
	logic [3:0]  bit_q, bit_d;
	logic [7:0]  rx_q, rx_d, tx_q, tx_d;
	logic        apf_q, apf_d, df_q, df_d, clash_q, clash_d;
	logic        hold_q, hold_d, dir_q, dir_d, busy_q, busy_d;
	logic        ackn_q, ackn_d, nack_q, nack_d, dfclr_q, dfclr_d;
	logic        sda_oe_q, sda_oe_d;
	logic [31:0] prdata_q, prdata_d;
	logic [sbp_pkg::TOUT_W-1:0] tcnt_q, tcnt_d;
	logic        tout, apf_set, apf_addr, apf_clr, df_set, df_clr;
	logic        tx_bit;

	assign tx_bit = tx_q[~bit_q[2:0]];
	assign tout   = ctrl_q.tout_en & busy_q &
			(tcnt_q == sbp_pkg::TOUT_W'(TOUT_CYC - 1));

	always_comb begin
		ctrl_d   = ctrl_q;
		st_d     = st_q;
		bit_d    = bit_q;
		rx_d     = rx_q;
		tx_d     = tx_q;
		dir_d    = dir_q;
		busy_d   = busy_q;
		nack_d   = nack_q;
		ackn_d   = ackn_q;
		clash_d  = clash_q;
		apf_set  = 1'b0;
		apf_addr = 1'b0;
		df_set   = 1'b0;
		sda_oe_d = 1'b0;
		// software side
		if (wr & hit(I_PADDR, sbp_pkg::REG_CTRL)) begin
			ctrl_d.enable  = I_PWDATA[sbp_pkg::CTRL_EN_BIT];
			ctrl_d.tout_en = I_PWDATA[sbp_pkg::CTRL_TOUT_BIT];
			ctrl_d.addr    = I_PWDATA[sbp_pkg::CTRL_ADDR_LSB +:
						sbp_pkg::SADDR_W];
		end
		if (wr & hit(I_PADDR, sbp_pkg::REG_DATA))
			tx_d = I_PWDATA[sbp_pkg::DATA_W-1:0];
		if (cmd_wr)
			ackn_d = I_PWDATA[sbp_pkg::CMD_ACKN_BIT];
		if (st_wr & I_PWDATA[sbp_pkg::STAT_CLR_BIT])
			clash_d = 1'b0;
		if (cmd == sbp_pkg::CMD_DONE)
			st_d = sbp_pkg::ST_IDLE;
		// bus timing counter, restarted by any line activity
		tcnt_d = (scl_q[1] ^ scl_q[2]) | (sda_q[1] ^ sda_q[2]) | ~busy_q
			? '0 : tcnt_q + 1'b1;
		// bus side
		unique case (st_q)
			sbp_pkg::ST_IDLE, sbp_pkg::ST_ADDR, sbp_pkg::ST_RX: ;
			sbp_pkg::ST_AACK, sbp_pkg::ST_DACK: sda_oe_d = ~ackn_q;
			sbp_pkg::ST_TX: sda_oe_d = ~tx_bit;
			sbp_pkg::ST_TACK: ;
		endcase
		unique case (st_q)
			sbp_pkg::ST_ADDR, sbp_pkg::ST_RX: begin
				if (scl_rise) begin
					rx_d  = {rx_q[6:0], sda_s};
					bit_d = bit_q + 1'b1;
				end else if (scl_fall && bit_q == sbp_pkg::BYTE_BITS) begin
					bit_d = '0;
					if (st_q == sbp_pkg::ST_RX) begin
						df_set = 1'b1;
						st_d   = sbp_pkg::ST_DACK;
					end else if (rx_q[7:1] == ctrl_q.addr) begin
						apf_set  = 1'b1;
						apf_addr = 1'b1;
						dir_d    = rx_q[0];
						st_d     = sbp_pkg::ST_AACK;
					end else
						st_d = sbp_pkg::ST_IDLE;
				end
			end
			sbp_pkg::ST_AACK, sbp_pkg::ST_DACK: begin
				if (scl_fall) begin
					if (ackn_q)
						st_d = sbp_pkg::ST_IDLE;
					else if (st_q == sbp_pkg::ST_AACK && dir_q) begin
						df_set = 1'b1;
						st_d   = sbp_pkg::ST_TX;
					end else
						st_d = sbp_pkg::ST_RX;
				end
			end
			sbp_pkg::ST_TX: begin
				// next bit only after scl falls: no sda change while high
				if (scl_rise & tx_bit & ~sda_s)
					clash_d = 1'b1;
				if (scl_fall) begin
					bit_d = bit_q + 1'b1;
					if (bit_q == sbp_pkg::BYTE_BITS - 4'h1) begin
						bit_d = '0;
						st_d  = sbp_pkg::ST_TACK;
					end
				end
			end
			sbp_pkg::ST_TACK: begin
				if (scl_rise)
					nack_d = sda_s;
				else if (scl_fall) begin
					if (nack_q)
						st_d = sbp_pkg::ST_IDLE;
					else begin
						df_set = 1'b1;
						st_d   = sbp_pkg::ST_TX;
					end
				end
			end
			sbp_pkg::ST_IDLE: ;
		endcase
		if (start_ev) begin
			if (!busy_q)
				clash_d = 1'b0;
			busy_d = 1'b1;
			bit_d  = '0;
			st_d   = tout ? sbp_pkg::ST_IDLE : sbp_pkg::ST_ADDR;
		end else if (stop_ev) begin
			if (st_q != sbp_pkg::ST_IDLE && st_q != sbp_pkg::ST_ADDR)
				apf_set = 1'b1;
			busy_d = 1'b0;
			st_d   = sbp_pkg::ST_IDLE;
		end
		if (tout) begin
			busy_d = 1'b0;
			st_d   = sbp_pkg::ST_IDLE;
		end
		if (!ctrl_q.enable) begin
			st_d     = sbp_pkg::ST_IDLE;
			apf_set  = 1'b0;
			apf_addr = 1'b0;
			df_set   = 1'b0;
		end
		// flags: a set in the same cycle as a clear wins
		apf_clr = (st_wr & I_PWDATA[sbp_pkg::STAT_APF_BIT]) |
			(cmd != sbp_pkg::CMD_NONE);
		apf_d   = apf_set | (apf_q & ~apf_clr);
		dfclr_d = (cmd == sbp_pkg::CMD_RESP);
		df_clr  = dfclr_q | (st_wr & I_PWDATA[sbp_pkg::STAT_DF_BIT]) |
			(cmd == sbp_pkg::CMD_DONE);
		df_d    = df_set | (df_q & ~df_clr);
		// clock stretch follows the address-match and data flags; a STOP sets the address flag without it
		if (apf_addr | df_set)
			hold_d = 1'b1;
		else if ((apf_q & apf_clr) | (df_q & df_clr) | ~ctrl_q.enable)
			hold_d = 1'b0;
		else
			hold_d = hold_q;
	end

	always_ff @(posedge I_CLK) begin
		if (I_SRST) begin
			ctrl_q   <= '0;
			st_q     <= sbp_pkg::ST_IDLE;
			bit_q    <= '0;
			rx_q     <= '0;
			tx_q     <= '0;
			apf_q    <= 1'b0;
			df_q     <= 1'b0;
			dfclr_q  <= 1'b0;
			clash_q  <= 1'b0;
			hold_q   <= 1'b0;
			dir_q    <= 1'b0;
			busy_q   <= 1'b0;
			ackn_q   <= 1'b0;
			nack_q   <= 1'b0;
			sda_oe_q <= 1'b0;
			tcnt_q   <= '0;
			prdata_q <= '0;
		end else begin
			ctrl_q   <= ctrl_d;
			st_q     <= st_d;
			bit_q    <= bit_d;
			rx_q     <= rx_d;
			tx_q     <= tx_d;
			apf_q    <= apf_d;
			df_q     <= df_d;
			dfclr_q  <= dfclr_d;
			clash_q  <= clash_d;
			hold_q   <= hold_d;
			dir_q    <= dir_d;
			busy_q   <= busy_d;
			ackn_q   <= ackn_d;
			nack_q   <= nack_d;
			sda_oe_q <= sda_oe_d;
			tcnt_q   <= tcnt_d;
			prdata_q <= prdata_d;
		end
	end

	// ------------------------------------------------------------------
	// outputs and read mux
	// ------------------------------------------------------------------
	assign O_SCL_O  = 1'b0;
	assign O_SCL_OE = hold_q;
	assign O_SDA_O  = 1'b0;
	assign O_SDA_OE = sda_oe_q;
	// read word registered in setup, stands through the access phase
	assign O_PRDATA = prdata_q;

	always_comb begin
		stat.address_stop_flag   = apf_q;
		stat.data_flag           = df_q;
		stat.tx_clash            = clash_q;
		stat.clock_stretch_state = hold_q;
		stat.read_dir            = dir_q;
		stat.bus_condition       = busy_q ? sbp_pkg::BUS_BUSY
					: sbp_pkg::BUS_IDLE;
		stat.rx_nack             = nack_q;
		prdata_d = '0;
		if (hit(I_PADDR, sbp_pkg::REG_CTRL))
			prdata_d = {16'h0, 1'b0, ctrl_q.addr, 6'h0,
				ctrl_q.tout_en, ctrl_q.enable};
		else if (hit(I_PADDR, sbp_pkg::REG_STAT))
			prdata_d = {24'h0, stat};
		else if (hit(I_PADDR, sbp_pkg::REG_DATA))
			prdata_d = {24'h0, dir_q ? tx_q : rx_q};
	end

	// ------------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------------
	default clocking cb @(posedge I_CLK); endclocking
	default disable iff (I_SRST);

	start_clash_clr_a: assert property (
		start_ev && !busy_q |=> !clash_q)
		else $error("clash flag kept after start");
	rstart_clash_keep_a: assert property (
		start_ev && busy_q && clash_q && !st_wr |=> clash_q)
		else $error("clash flag lost on repeated start");
	race_hold_keep_a: assert property (
		apf_addr && apf_clr |=> apf_q && hold_q && O_SCL_OE)
		else $error("address flag race released the clock");
	tout_start_drop_a: assert property (
		start_ev && tout |=> st_q == sbp_pkg::ST_IDLE && !busy_q)
		else $error("transaction not dropped at timeout start");
	resp_df_delay_a: assert property (
		cmd == sbp_pkg::CMD_RESP && df_q && !df_set |=>
		df_q ##1 !df_q)
		else $error("data flag not cleared one cycle after response");
	hold_drives_scl_a: assert property (
		hold_q |-> O_SCL_OE && !O_SCL_O)
		else $error("clock stretch without scl drive");
	addr_sets_hold_a: assert property (
		apf_addr |=> hold_q && apf_q && stat.clock_stretch_state)
		else $error("address match did not stretch the clock");
	resp_release_a: assert property (
		hold_q && !apf_q && df_q && cmd == sbp_pkg::CMD_RESP && !df_set
		|=> ##1 !hold_q)
		else $error("clock not released after response");
endmodule : sbp_slave
`default_nettype wire

// ==== verif/sbp_master_model.sv ====
// two-wire bus master model driving the slave under test
`timescale 1ns/100ps
`default_nettype none
module sbp_master_model (
	// wire levels
	input  wire logic scl,
	input  wire logic sda,
	// open-drain pulls, high = pull low
	output logic      scl_oe,
	output logic      sda_oe
);
	// byte seen on the wire during the last transfer
	logic [7:0] got;

	initial begin
		scl_oe = 1'h0;
		sda_oe = 1'h0;
	end

	// ------------------------------------------------------------------
	// framing
	// ------------------------------------------------------------------
	task automatic start;
		sda_oe = 1'h1;
		#200 scl_oe = 1'h1;
	endtask : start

	task automatic stop;
		#100 sda_oe = 1'h1;
		#150 scl_oe = 1'h0;
		wait (scl);
		#200 sda_oe = 1'h0;
		#200;
	endtask : stop

	task automatic restart;
		#100 sda_oe = 1'h0;
		#150 scl_oe = 1'h0;
		wait (scl);
		#100 start();
	endtask : restart

	// ------------------------------------------------------------------
	// one bit: data set mid-low, waits while the slave stretches
	// ------------------------------------------------------------------
	task automatic bit_clk(input logic b, output logic s);
		#100 sda_oe = ~b;
		#150 scl_oe = 1'h0;
		wait (scl);
		#75 s = sda;
		#75 scl_oe = 1'h1;
	endtask : bit_clk

	task automatic xfer(input logic [7:0] d, output logic ack);
		logic s;
		for (int i = 7; i >= 0; i--) begin
			bit_clk(d[i], s);
			got[i] = s;
		end
		bit_clk(1'h1, ack);
	endtask : xfer
endmodule : sbp_master_model
`default_nettype wire

// ==== verif/test_i2c_slave_flag_handling.sv ====
// self-checking bench of the serial bus port slave
`timescale 1ns/100ps
`default_nettype none
module test_i2c_slave_flag_handling;
	logic        clk = 1'h0;
	logic        srst = 1'h1;
	logic        psel = 1'h0;
	logic        pen = 1'h0;
	logic        pwr = 1'h0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic [31:0] rd;
	logic        err;
	logic        pready;
	logic        pslverr;
	logic        scl_oe;
	logic        sda_oe;
	logic        m_scl_oe;
	logic        m_sda_oe;
	logic        scl_o;
	logic        sda_o;
	logic        ack;
	wire logic   scl;
	wire logic   sda;
	int          fail_count = 0;
	int          cmp_count = 0;
	int          cyc = 0;

	assign scl = ~((scl_oe & ~scl_o) | m_scl_oe);
	assign sda = ~((sda_oe & ~sda_o) | m_sda_oe);
	always #25 clk = ~clk;

	sbp_slave #(.TOUT_CYC(20)) dut (
		.I_CLK(clk), .I_SRST(srst), .I_PSEL(psel), .I_PENABLE(pen),
		.I_PWRITE(pwr), .I_PADDR(paddr), .I_PWDATA(pwdata),
		.O_PRDATA(prdata), .O_PREADY(pready), .O_PSLVERR(pslverr),
		.I_SCL(scl), .O_SCL_O(scl_o), .O_SCL_OE(scl_oe),
		.I_SDA(sda), .O_SDA_O(sda_o), .O_SDA_OE(sda_oe)
	);

	sbp_master_model m (
		.scl(scl), .sda(sda), .scl_oe(m_scl_oe), .sda_oe(m_sda_oe)
	);

	// ------------------------------------------------------------------
	// tasks
	// ------------------------------------------------------------------
	task automatic chk(input string nm, input logic [31:0] s, e);
		cmp_count++;
		if (s !== e) begin
			fail_count++;
			$display("[ERR] %s expected %h seen %h", nm, e, s);
		end
	endtask : chk

	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		@(posedge clk);
		psel <= 1'h1;
		pwr <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		pen <= 1'h1;
		do @(posedge clk); while (pready !== 1'h1);
		rd = prdata;
		err = pslverr;
		psel <= 1'h0;
		pen <= 1'h0;
	endtask : apb

	task automatic poll(input int b);
		do apb(1'h0, sbp_pkg::REG_STAT, 32'h0); while (rd[b] !== 1'h1);
	endtask : poll

	task automatic final_report;
		$display("checks %0d mismatches %0d", cmp_count, fail_count);
		if (fail_count == 0 && cmp_count > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : final_report

	always @(posedge clk) begin
		cyc++;
		if (cyc == 5000) begin
			fail_count++;
			final_report();
		end
	end

	// ------------------------------------------------------------------
	// tests
	// ------------------------------------------------------------------
	initial begin
		repeat (2) @(posedge clk);
		srst <= 1'h0;
		apb(1'h0, sbp_pkg::REG_STAT, 32'h0);
		chk("stat_rst", rd, 32'h20);
		apb(1'h0, 8'h10, 32'h0);
		chk("unmapped", {err, rd[30:0]}, 32'h80000000);
		$display("test reset done");
		apb(1'h1, sbp_pkg::REG_CTRL, 32'h2A01);
		fork
			begin
				m.start();
				m.xfer(8'h54, ack);
			end
			begin
				poll(0);
				chk("addr_stat", rd, 32'h69);
				chk("addr_hold", scl_oe, 32'h1);
				chk("scl_low", scl, 32'h0);
				apb(1'h1, sbp_pkg::REG_STAT, 32'h4);
				apb(1'h1, sbp_pkg::REG_CMD, 32'h3);
			end
		join
		chk("addr_ack", ack, 32'h0);
		$display("test address done");
		fork
			m.xfer(8'hA5, ack);
			begin
				poll(1);
				chk("data_stat", rd, 32'h6A);
				apb(1'h0, sbp_pkg::REG_DATA, 32'h0);
				chk("rx_byte", rd, 32'hA5);
				apb(1'h1, sbp_pkg::REG_CMD, 32'h3);
				#1 chk("df_hold", scl_oe, 32'h1);
				@(posedge clk);
				#1 chk("df_rel", scl_oe, 32'h0);
			end
		join
		chk("data_ack", ack, 32'h0);
		m.stop();
		repeat (10) @(posedge clk);
		apb(1'h0, sbp_pkg::REG_STAT, 32'h0);
		chk("stop_stat", rd, 32'h21);
		chk("stop_free", scl_oe, 32'h0);
		apb(1'h1, sbp_pkg::REG_STAT, 32'h1);
		apb(1'h0, sbp_pkg::REG_STAT, 32'h0);
		chk("idle_clr", rd, 32'h20);
		$display("test data done");
		m.start();
		m.xfer(8'h22, ack);
		m.stop();
		chk("nack", ack, 32'h1);
		repeat (10) @(posedge clk);
		apb(1'h0, sbp_pkg::REG_STAT, 32'h0);
		chk("foreign", rd, 32'h20);
		$display("test foreign done");
		fork
			begin
				m.start();
				m.xfer(8'h55, ack);
				chk("rd_addr_ack", ack, 32'h0);
				m.xfer(8'hDF, ack);
			end
			begin
				poll(0);
				chk("rd_addr_stat", rd, 32'h79);
				chk("rd_scl_low", scl, 32'h0);
				apb(1'h1, sbp_pkg::REG_CMD, 32'h3);
				poll(1);
				chk("tx_stat", rd, 32'h7A);
				apb(1'h1, sbp_pkg::REG_DATA, 32'h3C);
				apb(1'h1, sbp_pkg::REG_CMD, 32'h3);
			end
		join
		chk("rd_nack", ack, 32'h1);
		chk("rd_byte", m.got, 32'h1C);
		m.restart();
		m.stop();
		repeat (10) @(posedge clk);
		apb(1'h0, sbp_pkg::REG_STAT, 32'h0);
		chk("rstart_keep", rd, 32'hB4);
		m.start();
		m.stop();
		repeat (10) @(posedge clk);
		apb(1'h0, sbp_pkg::REG_STAT, 32'h0);
		chk("start_clr", rd, 32'hB0);
		$display("test read done");
		apb(1'h1, sbp_pkg::REG_CTRL, 32'h2A03);
		m.start();
		repeat (40) @(posedge clk);
		apb(1'h0, sbp_pkg::REG_STAT, 32'h0);
		chk("tout_idle", rd, 32'hB0);
		m.stop();
		$display("test timeout done");
		final_report();
	end
endmodule : test_i2c_slave_flag_handling
`default_nettype wire
